// ---- core/uft_cfg.svh ----
// uft_cfg: register offsets, field positions, reset values and timing counts
// assumes inclusion by bare name from the package and the core
`ifndef UFT_CFG_SVH
`define UFT_CFG_SVH

// register byte offsets
`define UFT_A_DATA 8'h00
`define UFT_A_CTRL 8'h04
`define UFT_A_DIV 8'h08
`define UFT_A_RATE 8'h0C
`define UFT_A_TXBUF 8'h10
`define UFT_A_RXBUF 8'h14
`define UFT_A_IER 8'h18
`define UFT_A_STAT 8'h1C
`define UFT_A_LEVEL 8'h20

// control word fields
`define UFT_C_EN 0
`define UFT_C_WLEN 1
`define UFT_C_STOP2 3
`define UFT_C_PAREN 4
`define UFT_C_PARODD 5
`define UFT_C_RTS 6
`define UFT_C_AUTO 7
`define UFT_C_ALT 8
`define UFT_D_CPB 16
`define UFT_D_CPBEN 24
`define UFT_B_SIZE 16

// ram and buffer limits
`define UFT_AW 12
`define UFT_FIFO_MIN 16
`define UFT_FIFO_MAX 2047
`define UFT_TX_BASE_RST 12'h000
`define UFT_RX_BASE_RST 12'h800
`define UFT_AFC_MARGIN 8

// receive trigger levels
`define UFT_TRIG0 12'h001
`define UFT_TRIG1 12'h004
`define UFT_TRIG2 12'h008
`define UFT_TRIG3 12'h00E

// timing: 1 MHz reference is 16 MHz over 16
`define UFT_CLK_NS 10
`define UFT_CLK_MHZ (1000 / `UFT_CLK_NS)
`define UFT_PCLK_MHZ 16
`define UFT_CPB_REF 8'h0F
`define UFT_DIV_RST 16'h0068
`define UFT_TO_CHARS 4

`endif

// ---- core/uft_pkg.sv ----
// uft_pkg: state types of the serial port core and its tick generator
// assumes uft_cfg.svh on the include path
`include "uft_cfg.svh"

package uft_pkg;

  // frame phase, gray along idle-start-data-parity-stop
  typedef enum logic [2:0] {
    UFT_IDLE  = 3'h0,
    UFT_START = 3'h1,
    UFT_DATA  = 3'h3,
    UFT_PAR   = 3'h2,
    UFT_STOP  = 3'h6
  } uft_ph_t;

  typedef struct packed {
    logic               en;
    logic               mode_alt;
    logic               fc_auto;
    logic               rts_man;
    logic [1:0]         wlen;
    logic               stop2;
    logic               par_en;
    logic               par_odd;
    logic [15:0]        div;
    logic [7:0]         cpb;
    logic [`UFT_AW-1:0] tx_base;
    logic [10:0]        tx_size;
    logic [`UFT_AW-1:0] rx_base;
    logic [10:0]        rx_size;
    logic [3:0]         ier;
    logic [1:0]         trig;
    logic [10:0]        tx_rd;
    logic [10:0]        tx_wr;
    logic [11:0]        tx_fill;
    logic [10:0]        rx_rd;
    logic [10:0]        rx_wr;
    logic [11:0]        rx_fill;
    uft_ph_t            tx_st;
    logic [7:0]         tx_sh;
    logic [2:0]         tx_bit;
    logic [8:0]         tx_cnt;
    logic               tx_par;
    logic               txd;
    uft_ph_t            rx_st;
    logic [7:0]         rx_sh;
    logic [2:0]         rx_bit;
    logic [7:0]         rx_cnt;
    logic               rx_par;
    logic               rx_one;
    logic               rx_arm;
    logic [7:0]         bp;
    logic [6:0]         to_cnt;
    logic               to_p;
    logic               tx_emp_p;
    logic               ms_p;
    logic               ovr;
    logic               perr;
    logic               ferr;
    logic               brk;
    logic               cts_q;
    logic               rts_n;
    logic [31:0]        rdata;
  } uft_st_t;

  typedef struct packed {
    logic [6:0]  acc;
    logic [15:0] cnt;
    logic        sub;
  } uft_tk_t;

endpackage

// ---- core/uft_serial_core.sv ----
// uft_serial_core: one serial port with ram ring buffers moved by hardware
// assumes clk at 100 MHz, synchronous high reset, single-cycle register port
`timescale 1ns/1ns
`default_nettype none
`include "uft_cfg.svh"

// Notes on behaviour
// - each ring sits in ram at a chosen base, sized 16 to 2047 bytes
// - bytes move between rings and the lines with no software action
// - transmit and receive engines run independently and concurrently
// - two-wire: send whenever data waits, receive any time, no flow control
// - four-wire: receiver raises rts when ready; sender sends while cts asserted
// - automatic flow control drives rts from receive ring fill
// - one-wire on secondary port: transmit only, rxd pin released
// - primary defaults four-wire, secondary two-wire, unless changed before enable
// - preset rates 4800, 9600, 19200, 38400, 76800 and 115200 bps
// - a 16-bit divisor alone gives 1 MHz over divisor
// - with 8-bit clocks-per-bit, rate is 16 MHz over divisor times cpb plus one
// - top recommended rate 4 Mbps with divisor one and cpb three
// - parity on or off, odd or even
// - five to eight data bits per character
// - one stop bit, or 1.5 for five bits and 2 otherwise
// - rts initial level settable, effective only primary four-wire
// - transmit-empty event when the last byte starts out
// - receive-available while fill reaches 1, 4, 8 or 14
// - timeout after four idle character times with data waiting
// - reading a character clears timeout and restarts its timer
// - line status event on break, framing, parity or overrun
// - modem status event on cts change, primary four-wire only
module uft_serial_core #(
  parameter bit PRIMARY = 1'b1
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  // serial line
  output logic             txd,
  input  wire logic        rxd,
  output logic             rts_n,
  input  wire logic        cts_n,
  // events and pin ownership
  output logic             irq,
  output logic             rxd_used,
  output logic             fc_used
);
  import uft_pkg::*;

  localparam int unsigned RAM_BYTES = 1 << `UFT_AW;

  uft_st_t            s_reg;
  uft_st_t            s_next;
  logic [7:0]         mem [RAM_BYTES];
  logic               fc4;
  logic               onew;
  logic               tx_push;
  logic               tx_pop;
  logic               rx_push;
  logic               rx_pop;
  logic               stat_rd;
  logic               rda;
  logic [3:0]         wb;
  logic [8:0]         stop_len;
  logic [6:0]         to_lim;
  logic [11:0]        trig_lvl;
  logic [`UFT_AW-1:0] tx_wa;
  logic [`UFT_AW-1:0] tx_ra;
  logic [`UFT_AW-1:0] rx_wa;
  logic [`UFT_AW-1:0] rx_ra;
  logic [7:0]         rx_byte;

  uft_tick_if tk ();

  uft_tick u_tick (
    .clk  (clk),
    .srst (srst),
    .tk   (tk)
  );

  function automatic uft_st_t rst_state();
    uft_st_t r;
    r = '0;
    r.div = `UFT_DIV_RST;
    r.cpb = `UFT_CPB_REF;
    r.tx_base = `UFT_TX_BASE_RST;
    r.rx_base = `UFT_RX_BASE_RST;
    r.tx_size = 11'(`UFT_FIFO_MIN);
    r.rx_size = 11'(`UFT_FIFO_MIN);
    r.txd = 1'b1;
    r.rts_n = 1'b1;
    r.cts_q = 1'b1;
    return r;
  endfunction

  // sizes below the floor are raised; 11 bits cap them at the ceiling
  function automatic logic [10:0] clamp_size(input logic [10:0] v);
    return (v < 11'(`UFT_FIFO_MIN)) ? 11'(`UFT_FIFO_MIN) : v;
  endfunction

  function automatic logic [10:0] ring_next(input logic [10:0] p, input logic [10:0] sz);
    return (p == sz - 11'h001) ? 11'h000 : p + 11'h001;
  endfunction

  // divisors off the 1 MHz reference for the preset rates
  function automatic logic [15:0] preset_div(input logic [2:0] sel);
    case (sel)
      3'h0:    return 16'h00D0;
      3'h1:    return 16'h0068;
      3'h2:    return 16'h0034;
      3'h3:    return 16'h001A;
      3'h4:    return 16'h000D;
      3'h5:    return 16'h0009;
      default: return 16'h0068;
    endcase
  endfunction

  // mode and pin ownership
  assign fc4 = PRIMARY && !s_reg.mode_alt;
  assign onew = !PRIMARY && s_reg.mode_alt;
  assign rxd_used = !onew;
  assign fc_used = fc4;

  // ring addresses: base plus offset, wrapping in ram
  assign tx_wa = s_reg.tx_base + `UFT_AW'(s_reg.tx_wr);
  assign tx_ra = s_reg.tx_base + `UFT_AW'(s_reg.tx_rd);
  assign rx_wa = s_reg.rx_base + `UFT_AW'(s_reg.rx_wr);
  assign rx_ra = s_reg.rx_base + `UFT_AW'(s_reg.rx_rd);

  // frame geometry
  assign wb = 4'(s_reg.wlen) + 4'h5;
  assign stop_len = !s_reg.stop2 ? 9'(s_reg.cpb) + 9'h001
                  : (s_reg.wlen == 2'h0) ? 9'(s_reg.cpb) + 9'h001 + 9'(s_reg.cpb[7:1]) + 9'h001
                  : {s_reg.cpb, 1'b0} + 9'h002;
  assign to_lim = 7'(`UFT_TO_CHARS) * (7'(wb) + 7'h2 + 7'(s_reg.par_en) + 7'(s_reg.stop2));
  assign rx_byte = s_reg.rx_sh >> (4'h8 - wb);

  always_comb
  begin
    case (s_reg.trig)
      2'h0:    trig_lvl = `UFT_TRIG0;
      2'h1:    trig_lvl = `UFT_TRIG1;
      2'h2:    trig_lvl = `UFT_TRIG2;
      default: trig_lvl = `UFT_TRIG3;
    endcase
  end

  // level event, drops with the fill
  assign rda = s_reg.rx_fill >= trig_lvl;

  // strobes with side effects; a full ring silently drops the written byte
  assign tx_push = wr && addr == `UFT_A_DATA && s_reg.tx_fill < 12'(s_reg.tx_size);
  assign rx_pop = rd && addr == `UFT_A_DATA && s_reg.rx_fill != 12'h000;
  assign stat_rd = rd && addr == `UFT_A_STAT;

  always_comb
  begin
    s_next = s_reg;
    s_next.rdata = 32'h0;
    tx_pop = 1'b0;
    rx_push = 1'b0;

    // clears first so that a same-cycle hardware set wins
    if (stat_rd)
    begin
      s_next.ovr = 1'b0;
      s_next.perr = 1'b0;
      s_next.ferr = 1'b0;
      s_next.brk = 1'b0;
      s_next.ms_p = 1'b0;
      s_next.tx_emp_p = 1'b0;
    end
    if (tx_push)
      s_next.tx_emp_p = 1'b0;

    // transmit engine, starts on a sub-bit enable
    if (s_reg.tx_st == UFT_IDLE)
    begin
      if (s_reg.en && s_reg.tx_fill != 12'h000 && (!fc4 || !cts_n) && tk.sub_en)
      begin
        s_next.tx_st = UFT_START;
        s_next.txd = 1'b0;
        s_next.tx_sh = mem[tx_ra];
        s_next.tx_cnt = 9'h000;
        s_next.tx_bit = 3'h0;
        s_next.tx_par = s_reg.par_odd;
        tx_pop = 1'b1;
        if (s_reg.tx_fill == 12'h001 && !tx_push)
          s_next.tx_emp_p = 1'b1;
      end
    end
    else if (tk.sub_en)
    begin
      // bit length is cpb plus one sub-bits
      if (s_reg.tx_cnt != ((s_reg.tx_st == UFT_STOP) ? stop_len - 9'h001 : 9'(s_reg.cpb)))
      begin
        s_next.tx_cnt = s_reg.tx_cnt + 9'h001;
      end
      else
      begin
        s_next.tx_cnt = 9'h000;
        unique case (s_reg.tx_st)
          UFT_START,
          UFT_DATA:
          begin
            if (s_reg.tx_st == UFT_DATA && 4'(s_reg.tx_bit) == wb - 4'h1)
            begin
              s_next.tx_st = s_reg.par_en ? UFT_PAR : UFT_STOP;
              s_next.txd = s_reg.par_en ? s_reg.tx_par : 1'b1;
            end
            else
            begin
              if (s_reg.tx_st == UFT_DATA)
                s_next.tx_bit = s_reg.tx_bit + 3'h1;
              s_next.tx_st = UFT_DATA;
              s_next.txd = s_reg.tx_sh[0];
              s_next.tx_par = s_reg.tx_par ^ s_reg.tx_sh[0];
              s_next.tx_sh = s_reg.tx_sh >> 1;
            end
          end
          UFT_PAR:
          begin
            s_next.tx_st = UFT_STOP;
            s_next.txd = 1'b1;
          end
          UFT_STOP:
            s_next.tx_st = UFT_IDLE;
          UFT_IDLE: ;
        endcase
      end
    end

    // receive engine, idle in one-wire mode
    if (!s_reg.en || onew)
    begin
      s_next.rx_st = UFT_IDLE;
      s_next.rx_arm = 1'b0;
    end
    else
    begin
      unique case (s_reg.rx_st)
        UFT_IDLE:
        begin
          // a start needs a high line first, so a held break counts once
          if (rxd)
            s_next.rx_arm = 1'b1;
          else if (s_reg.rx_arm)
          begin
            s_next.rx_st = UFT_START;
            s_next.rx_cnt = 8'h00;
            s_next.rx_arm = 1'b0;
          end
        end
        UFT_START:
        begin
          if (tk.sub_en)
          begin
            if (s_reg.rx_cnt != {1'b0, s_reg.cpb[7:1]})
              s_next.rx_cnt = s_reg.rx_cnt + 8'h01;
            else if (rxd)
              s_next.rx_st = UFT_IDLE; // glitch, not a start
            else
            begin
              s_next.rx_st = UFT_DATA;
              s_next.rx_cnt = 8'h00;
              s_next.rx_bit = 3'h0;
              s_next.rx_par = 1'b0;
              s_next.rx_one = 1'b0;
            end
          end
        end
        UFT_DATA,
        UFT_PAR,
        UFT_STOP:
        begin
          if (tk.sub_en && s_reg.rx_cnt != s_reg.cpb)
            s_next.rx_cnt = s_reg.rx_cnt + 8'h01;
          else if (tk.sub_en)
          begin
            // sample mid-bit
            s_next.rx_cnt = 8'h00;
            s_next.rx_one = s_reg.rx_one | rxd;
            if (s_reg.rx_st == UFT_DATA)
            begin
              s_next.rx_sh = {rxd, s_reg.rx_sh[7:1]};
              s_next.rx_par = s_reg.rx_par ^ rxd;
              if (4'(s_reg.rx_bit) == wb - 4'h1)
                s_next.rx_st = s_reg.par_en ? UFT_PAR : UFT_STOP;
              else
                s_next.rx_bit = s_reg.rx_bit + 3'h1;
            end
            else if (s_reg.rx_st == UFT_PAR)
            begin
              if ((s_reg.rx_par ^ rxd) != s_reg.par_odd)
                s_next.perr = 1'b1;
              s_next.rx_st = UFT_STOP;
            end
            else
            begin
              // low stop: framing error, with no high bit at all a break
              if (!rxd)
              begin
                s_next.ferr = 1'b1;
                // sticky: a later plain framing error must not wipe a break
                if (!s_reg.rx_one)
                  s_next.brk = 1'b1;
              end
              if (s_reg.rx_fill != 12'(s_reg.rx_size))
                rx_push = 1'b1;
              else
                s_next.ovr = 1'b1;
              s_next.rx_st = UFT_IDLE;
              s_next.rx_arm = rxd;
            end
          end
        end
        default:
          s_next.rx_st = UFT_IDLE;
      endcase
    end

    // free bit-period counter paces the timeout
    if (tk.sub_en)
      s_next.bp = (s_reg.bp == s_reg.cpb) ? 8'h00 : s_reg.bp + 8'h01;
    if (rx_push || rx_pop || s_reg.rx_fill == 12'h000)
    begin
      s_next.to_cnt = 7'h00;
      s_next.to_p = 1'b0;
    end
    else
    begin
      if (tk.sub_en && s_reg.bp == s_reg.cpb && s_reg.to_cnt != 7'h7F)
        s_next.to_cnt = s_reg.to_cnt + 7'h01;
      if (s_reg.ier[1] && s_reg.to_cnt >= to_lim)
        s_next.to_p = 1'b1;
    end

    // cts change seen only in four-wire mode
    s_next.cts_q = cts_n;
    if (s_reg.en && fc4 && cts_n != s_reg.cts_q)
      s_next.ms_p = 1'b1;

    // rts: automatic keeps headroom, manual follows software
    s_next.rts_n = !(s_reg.en && fc4 && (s_reg.fc_auto
                   ? s_reg.rx_fill + 12'(`UFT_AFC_MARGIN) < 12'(s_reg.rx_size)
                   : s_reg.rts_man));

    // ring pointers and fill
    if (tx_push)
      s_next.tx_wr = ring_next(s_reg.tx_wr, s_reg.tx_size);
    if (tx_pop)
      s_next.tx_rd = ring_next(s_reg.tx_rd, s_reg.tx_size);
    if (rx_push)
      s_next.rx_wr = ring_next(s_reg.rx_wr, s_reg.rx_size);
    if (rx_pop)
      s_next.rx_rd = ring_next(s_reg.rx_rd, s_reg.rx_size);
    s_next.tx_fill = s_reg.tx_fill + 12'(tx_push) - 12'(tx_pop);
    s_next.rx_fill = s_reg.rx_fill + 12'(rx_push) - 12'(rx_pop);

    // configuration writes, last so a ring redefinition wins
    if (wr)
    begin
      case (addr)
        `UFT_A_CTRL:
        begin
          s_next.en = wdata[`UFT_C_EN];
          if (!s_reg.en)
            s_next.mode_alt = wdata[`UFT_C_ALT];
          s_next.wlen = wdata[`UFT_C_WLEN+1:`UFT_C_WLEN];
          s_next.stop2 = wdata[`UFT_C_STOP2];
          s_next.par_en = wdata[`UFT_C_PAREN];
          s_next.par_odd = wdata[`UFT_C_PARODD];
          s_next.rts_man = wdata[`UFT_C_RTS];
          s_next.fc_auto = wdata[`UFT_C_AUTO];
        end
        `UFT_A_DIV:
        begin
          s_next.div = wdata[15:0];
          s_next.cpb = wdata[`UFT_D_CPBEN] ? wdata[`UFT_D_CPB+7:`UFT_D_CPB] : `UFT_CPB_REF;
        end
        `UFT_A_RATE:
        begin
          s_next.div = preset_div(wdata[2:0]);
          s_next.cpb = `UFT_CPB_REF;
        end
        `UFT_A_TXBUF:
        begin
          s_next.tx_base = wdata[`UFT_AW-1:0];
          s_next.tx_size = clamp_size(wdata[`UFT_B_SIZE+10:`UFT_B_SIZE]);
          s_next.tx_rd = 11'h000;
          s_next.tx_wr = 11'h000;
          s_next.tx_fill = 12'h000;
        end
        `UFT_A_RXBUF:
        begin
          s_next.rx_base = wdata[`UFT_AW-1:0];
          s_next.rx_size = clamp_size(wdata[`UFT_B_SIZE+10:`UFT_B_SIZE]);
          s_next.rx_rd = 11'h000;
          s_next.rx_wr = 11'h000;
          s_next.rx_fill = 12'h000;
        end
        `UFT_A_IER:
        begin
          s_next.ier = wdata[3:0];
          s_next.trig = wdata[5:4];
        end
        default: ;
      endcase
    end

    // register reads, answered one cycle later
    if (rd)
    begin
      case (addr)
        `UFT_A_DATA:
          s_next.rdata = rx_pop ? {24'h0, mem[rx_ra]} : 32'h0;
        `UFT_A_CTRL:
          s_next.rdata = {23'h0, s_reg.mode_alt, s_reg.fc_auto, s_reg.rts_man, s_reg.par_odd,
                          s_reg.par_en, s_reg.stop2, s_reg.wlen, s_reg.en};
        `UFT_A_DIV:
          s_next.rdata = {8'h0, s_reg.cpb, s_reg.div};
        `UFT_A_TXBUF:
          s_next.rdata = {5'h0, s_reg.tx_size, 4'h0, s_reg.tx_base};
        `UFT_A_RXBUF:
          s_next.rdata = {5'h0, s_reg.rx_size, 4'h0, s_reg.rx_base};
        `UFT_A_IER:
          s_next.rdata = {26'h0, s_reg.trig, s_reg.ier};
        `UFT_A_STAT:
          s_next.rdata = {19'h0, s_reg.tx_st != UFT_IDLE, s_reg.ms_p, s_reg.to_p, rda,
                          s_reg.tx_emp_p, !s_reg.rts_n, !cts_n, s_reg.brk, s_reg.ferr,
                          s_reg.perr, s_reg.ovr, s_reg.rx_fill != 12'h000,
                          s_reg.tx_fill == 12'h000};
        `UFT_A_LEVEL:
          s_next.rdata = {4'h0, s_reg.rx_fill, 4'h0, s_reg.tx_fill};
        default:
          s_next.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      s_reg <= rst_state();
    else
      s_reg <= s_next;
  end

  // ram: software fills the transmit ring, the receiver fills its own
  always_ff @(posedge clk)
  begin
    if (tx_push)
      mem[tx_wa] <= wdata[7:0];
    if (rx_push)
      mem[rx_wa] <= rx_byte;
  end

  // outputs
  assign tk.div = s_reg.div;
  assign rdata = s_reg.rdata;
  assign txd = s_reg.txd;
  assign rts_n = s_reg.rts_n;
  assign irq = (s_reg.ier[0] && s_reg.tx_emp_p)
            || (s_reg.ier[1] && (rda || s_reg.to_p))
            || (s_reg.ier[2] && (s_reg.ovr || s_reg.perr || s_reg.ferr || s_reg.brk))
            || (s_reg.ier[3] && s_reg.ms_p);

endmodule

`default_nettype wire

// ---- core/uft_tick.sv ----
// uft_tick: 16 MHz enable from the system clock, then divided by the divisor
// assumes clk at 100 MHz and a synchronous high reset
`timescale 1ns/1ns
`default_nettype none
`include "uft_cfg.svh"

module uft_tick (
  // clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // divisor in, sub-bit enable out
  uft_tick_if.gen   tk
);
  import uft_pkg::*;

  uft_tk_t t_reg;
  uft_tk_t t_next;

  // fractional accumulator: average 16 MHz, jitter of one clk is accepted
  always_comb
  begin
    t_next = t_reg;
    t_next.sub = 1'b0;
    if (t_reg.acc + 7'(`UFT_PCLK_MHZ) >= 7'(`UFT_CLK_MHZ))
    begin
      t_next.acc = 7'(t_reg.acc + 7'(`UFT_PCLK_MHZ) - 7'(`UFT_CLK_MHZ));
      // divisor of zero behaves as one
      if (t_reg.cnt + 16'h0001 >= tk.div)
      begin
        t_next.cnt = 16'h0000;
        t_next.sub = 1'b1;
      end
      else
      begin
        t_next.cnt = t_reg.cnt + 16'h0001;
      end
    end
    else
    begin
      t_next.acc = 7'(t_reg.acc + 7'(`UFT_PCLK_MHZ));
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      t_reg <= '0;
    else
      t_reg <= t_next;
  end

  assign tk.sub_en = t_reg.sub;

endmodule

`default_nettype wire

// ---- core/uft_tick_if.sv ----
// uft_tick_if: divisor out to the tick generator, sub-bit enable back
// assumes one clock domain shared by both ends
`timescale 1ns/1ns
`default_nettype none

interface uft_tick_if;
  logic [15:0] div;
  logic        sub_en;
  modport gen (input div, output sub_en);
  modport eng (output div, input sub_en);
endinterface

`default_nettype wire

// ---- tb/uft_far_end.sv ----
// uft_far_end: remote serial device that echoes every character it gets
// assumes 25 clocks per bit (divisor 1, cpb 3), 8 data bits with parity
`timescale 1ns/1ns
`default_nettype none

module uft_far_end (
  // clock
  input  wire logic clk,
  // serial line
  input  wire logic txd,
  output logic      rxd,
  input  wire logic rts_n,
  output logic      cts_n,
  // parity kind and tallies
  input  wire logic odd,
  output int        sent,
  output int        bad
);
  localparam int BT = 25;
  logic [7:0]  q[$];
  logic [7:0]  rb;
  logic [7:0]  eb;
  logic [10:0] fr;

  // line idles high via pull-up; always ready to take data
  initial
  begin
    rxd = 1'b1;
    cts_n = 1'b0;
    sent = 0;
    bad = 0;
  end

  // receiver samples mid-bit; jitter of the 16 MHz enable is well inside
  always
  begin
    @(negedge txd);
    repeat (BT / 2) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      repeat (BT) @(posedge clk);
      rb[i] = txd;
    end
    repeat (BT) @(posedge clk);
    if (txd !== (^rb ^ odd)) bad++;
    repeat (BT) @(posedge clk);
    if (txd !== 1'b1) bad++;
    q.push_back(rb);
  end

  // echo only while the port requests data
  always
  begin
    @(posedge clk);
    while (!(q.size() > 0 && rts_n === 1'b0))
      @(posedge clk);
    eb = q.pop_front();
    fr = {1'b1, ^eb ^ odd, eb, 1'b0};
    for (int i = 0; i < 11; i++)
      repeat (BT) @(posedge clk) rxd <= fr[i];
    sent++;
  end
endmodule

`default_nettype wire

// ---- tb/uft_serial_core_asserts.sv ----
// uft_serial_core_asserts: port-level checks of the serial port core
// assumes binding onto uft_serial_core, one clock, srst synchronous high
`timescale 1ns/1ns
`default_nettype none

module uft_serial_core_asserts #(
  parameter bit PRIMARY = 1'b1
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // line and events
  input wire logic        txd,
  input wire logic        rxd,
  input wire logic        rts_n,
  input wire logic        cts_n,
  input wire logic        irq,
  input wire logic        rxd_used,
  input wire logic        fc_used
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // port comes out of reset quiet and owning its default pins
  reset_idle_a: assert property (
    $fell(srst) |-> txd && rts_n && !irq && rxd_used && fc_used == PRIMARY)
    else $error("outputs not idle after reset");
  // read data only in the cycle after a read
  quiet_rd_a: assert property (!rd |=> rdata == 32'h0)
    else $error("read data outside read answer");
  unmapped_a: assert property (rd && addr > 8'h20 |=> rdata == 32'h0)
    else $error("unmapped address read nonzero");
  data_byte_a: assert property (rd && addr == 8'h00 |=> rdata[31:8] == 24'h0)
    else $error("data read wider than a character");
  // rts only driven when the port owns flow control
  rts_own_a: assert property (!fc_used |-> rts_n)
    else $error("rts asserted without flow control");
  // fills never exceed the largest ring
  fill_range_a: assert property (
    rd && addr == 8'h20 |=> rdata[31:27] == 5'h00 && rdata[15:11] == 5'h00)
    else $error("ring fill beyond largest ring size");
  rx_pin_a: assert property (fc_used |-> rxd_used)
    else $error("four-wire port released rxd");
  // a txd level never held under five clocks, below one sub-bit of six
  txd_hold_a: assert property ($changed(txd) |=> $stable(txd)[*4])
    else $error("txd level too short");
endmodule

bind uft_serial_core uft_serial_core_asserts #(.PRIMARY(PRIMARY)) chk (
  .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .txd(txd), .rxd(rxd), .rts_n(rts_n), .cts_n(cts_n),
  .irq(irq), .rxd_used(rxd_used), .fc_used(fc_used));

`default_nettype wire

// ---- tb/uft_serial_core_test.sv ----
// uft_serial_core_test: loop through a remote echo device, both parities
// assumes uft_far_end beside the primary port, 100 MHz clock
`timescale 1ns/1ns
`default_nettype none

module uft_serial_core_test;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        rd_q = 1'b0;
  logic        odd = 1'b0;
  logic [31:0] rdata;
  logic        txd, rxd, rts_n, cts_n, irq, rxd_used, fc_used;
  logic [31:0] exp_q[$];
  logic [7:0]  b[5];
  int          sent, bad, base, n;
  int          seed = 38720;
  int          miscompares = 0;
  int          comparisons = 0;

  always #5 clk = ~clk;

  uft_serial_core #(.PRIMARY(1'b1)) dut (
    .clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .txd(txd), .rxd(rxd), .rts_n(rts_n), .cts_n(cts_n),
    .irq(irq), .rxd_used(rxd_used), .fc_used(fc_used));

  uft_far_end far (
    .clk(clk), .txd(txd), .rxd(rxd), .rts_n(rts_n), .cts_n(cts_n),
    .odd(odd), .sent(sent), .bad(bad));

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want)
    begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, got, want);
    end
  endtask

  task automatic stop_test;
    miscompares = miscompares + bad;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // expected answer noted before the read goes out
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // answer stands one cycle only, so compare exactly then
  always @(posedge clk)
  begin
    rd_q <= rd;
    if (rd_q) chk(rdata, exp_q.pop_front());
  end

  initial
  begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    rd_reg(8'hFC, 32'h0);
    wr_reg(8'hFC, 32'hFFFF_FFFF);
    rd_reg(8'h20, 32'h0);
    wr_reg(8'h10, 32'h0010_0000);
    wr_reg(8'h14, 32'h0010_0800);
    wr_reg(8'h0C, 32'h0000_0002);
    rd_reg(8'h08, 32'h000F_0034);
    wr_reg(8'h08, 32'h0103_0001);
    wr_reg(8'h18, 32'h0000_0012);
    for (int p = 0; p < 2; p++)
    begin
      odd <= p[0];
      wr_reg(8'h04, 32'h0000_0097 | (p << 5));
      chk({31'h0, fc_used}, 32'h1);
      base = sent;
      for (int i = 0; i < 5; i++)
      begin
        b[i] = 8'($random(seed));
        wr_reg(8'h00, {24'h0, b[i]});
      end
      n = 0;
      while (sent < base + 5 && n < 20000)
      begin
        @(posedge clk);
        n++;
      end
      if (n == 20000)
      begin
        miscompares++;
        stop_test();
      end
      // let the last stop bit land in the ring
      repeat (40) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      rd_reg(8'h20, 32'h0005_0000);
      for (int i = 0; i < 5; i++)
        rd_reg(8'h00, {24'h0, b[i]});
      // empty rings, cts and rts asserted, tx-empty pending
      rd_reg(8'h1C, 32'h0000_01C1);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
    end
    stop_test();
  end
endmodule

`default_nettype wire
